// File: hw/iip_defines.vh
// constants for the isolated input port: register offsets, field widths,
// reset values and filter timing.
// assumes byte addressing on a plain register port, one 32-bit word per register.
`ifndef IIP_DEFINES_VH
`define IIP_DEFINES_VH

// ----------------------------------------
// port geometry
// ----------------------------------------
`define IIP_CHANNELS 128
`define IIP_IRQ_SRCS 16
`define IIP_GRP_SIZE 4
`define IIP_GROUPS 4
`define IIP_ADDR_W 6

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define IIP_OFF_DATA0 6'h00
`define IIP_OFF_DATA1 6'h04
`define IIP_OFF_DATA2 6'h08
`define IIP_OFF_DATA3 6'h0C
`define IIP_OFF_FILT 6'h10
`define IIP_OFF_IRQEN 6'h14
`define IIP_OFF_EDGE 6'h18
`define IIP_OFF_STAT 6'h1C
`define IIP_OFF_OVR 6'h20
`define IIP_OFF_GRP 6'h24

// ----------------------------------------
// reset values
// ----------------------------------------
`define IIP_FILT_RST 16'h0000
`define IIP_IRQEN_RST 16'h0000
`define IIP_EDGE_RST 16'h0000
`define IIP_STAT_RST 16'h0000

// ----------------------------------------
// filter timing
// ----------------------------------------
`define IIP_STABLE_SAMPLES 3
`define IIP_FILT_CNT_W 2

`endif

// File: hw/iip_filter.v
// noise and chatter filter for a bank of already synchronised inputs.
// assumes rawIn is in the clk domain; interval comes from a software register.
`timescale 1ns/1ns
`include "iip_defines.vh"

module iip_filter #(
   parameter WIDTH = `IIP_CHANNELS,
   parameter CNT_W = `IIP_FILT_CNT_W
) (
   input wire clk,
   input wire rstn,
   input wire [15:0] interval,
   input wire [WIDTH-1:0] rawIn,
   output wire [WIDTH-1:0] filtOut
);

   // the count is cut to the counter width on purpose
   localparam integer LAST_INT = `IIP_STABLE_SAMPLES - 1;
   localparam [CNT_W-1:0] LAST_CNT = LAST_INT[CNT_W-1:0];

   reg [15:0] preCnt_ff;
   reg [WIDTH-1:0] filt_ff;
   reg [CNT_W-1:0] cnt_ff [0:WIDTH-1];
   wire tick;
   integer i;

   // ----------------------------------------
   // sample prescaler
   // ----------------------------------------
   // one tick every interval cycles; interval zero means bypass
   assign tick = (interval != 16'h0000) && (preCnt_ff >= interval - 16'h0001);

   always @(posedge clk) begin
      if (!rstn) begin
         preCnt_ff <= 16'h0000;
      end else if (tick || interval == 16'h0000) begin
         preCnt_ff <= 16'h0000;
      end else begin
         preCnt_ff <= preCnt_ff + 16'h0001;
      end
   end

   // ----------------------------------------
   // per channel stability counters
   // ----------------------------------------
   // a level must be seen on several ticks in a row; a single glitch restarts it
   always @(posedge clk) begin
      if (!rstn) begin
         filt_ff <= {WIDTH{1'b1}};            // idle pin is high
         for (i = 0; i < WIDTH; i = i + 1) begin
            cnt_ff[i] <= {CNT_W{1'b0}};
         end
      end else if (interval == 16'h0000) begin
         filt_ff <= rawIn;
         for (i = 0; i < WIDTH; i = i + 1) begin
            cnt_ff[i] <= {CNT_W{1'b0}};
         end
      end else if (tick) begin
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (rawIn[i] == filt_ff[i]) begin
               cnt_ff[i] <= {CNT_W{1'b0}};
            end else if (cnt_ff[i] == LAST_CNT) begin
               filt_ff[i] <= rawIn[i];
               cnt_ff[i] <= {CNT_W{1'b0}};
            end else begin
               cnt_ff[i] <= cnt_ff[i] + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   assign filtOut = filt_ff;

endmodule // iip_filter

// File: hw/iip_top.v
// isolated 128-channel input port with filter and edge interrupts.
// assumes a single clk domain, pins asynchronous to it, and a bus master on
// the plain register port that never issues read and write together.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "iip_defines.vh"

module iip_top #(
   parameter NCH = `IIP_CHANNELS,
   parameter NSRC = `IIP_IRQ_SRCS
) (
   input wire clk,
   input wire rstn,
   input wire [NCH-1:0] inPins,
   input wire [`IIP_ADDR_W-1:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   output wire [31:0] regRdata,
   output wire irqReq
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // word address match, low two bits ignored
   function hit;
      input [`IIP_ADDR_W-1:0] addr;
      input [`IIP_ADDR_W-1:0] off;
      begin
         hit = (addr[`IIP_ADDR_W-1:2] == off[`IIP_ADDR_W-1:2]);
      end
   endfunction

   // or-reduce one group of four sources
   function groupAny;
      input [NSRC-1:0] vec;
      input integer grp;
      integer k;
      begin
         groupAny = 1'b0;
         for (k = 0; k < `IIP_GRP_SIZE; k = k + 1) begin
            groupAny = groupAny | vec[grp * `IIP_GRP_SIZE + k];
         end
      end
   endfunction

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   reg [NCH-1:0] sync1_ff;
   reg [NCH-1:0] sync2_ff;
   wire [NCH-1:0] filtLevel;
   wire [NCH-1:0] dataBits;

   reg [15:0] filtSet_ff;
   reg [NSRC-1:0] irqEn_ff;
   reg [NSRC-1:0] edgeRise_ff;
   reg [NSRC-1:0] status_ff;
   reg [NSRC-1:0] overrun_ff;
   reg [NSRC-1:0] prevSrc_ff;
   reg [31:0] rdata_ff;
   reg irq_ff;

   reg [NSRC-1:0] nxt_status;
   reg [NSRC-1:0] nxt_overrun;
   reg [31:0] nxt_rdata;
   reg [`IIP_GROUPS-1:0] grpReq;

   wire [NSRC-1:0] srcBits;
   wire [NSRC-1:0] riseEdge;
   wire [NSRC-1:0] fallEdge;
   wire [NSRC-1:0] srcEvent;
   wire [NSRC-1:0] statClr;
   wire [NSRC-1:0] ovrClr;
   wire wrStat;
   wire rdStat;
   wire wrOvr;
   wire [NSRC-1:0] edgeHit;
   wire [NSRC-1:0] pendMasked;
   wire selFilt;
   wire selIrqEn;
   wire selEdge;
   wire selStat;
   wire selOvr;
   wire selGrp;
   reg nxt_irq;
   integer g;

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   // two stages; only the second stage feeds the filter
   always @(posedge clk) begin
      if (!rstn) begin
         sync1_ff <= {NCH{1'b1}};
         sync2_ff <= {NCH{1'b1}};
      end else begin
         sync1_ff <= inPins;
         sync2_ff <= sync1_ff;
      end
   end

   // ----------------------------------------
   // input filter
   // ----------------------------------------
   // one shared setting for all channels keeps the register map small
   iip_filter #(
      .WIDTH(NCH),
      .CNT_W(`IIP_FILT_CNT_W)
   ) u_filter (
      .clk(clk),
      .rstn(rstn),
      .interval(filtSet_ff),
      .rawIn(sync2_ff),
      .filtOut(filtLevel)
   );

   // negative logic: high pin reads as zero
   assign dataBits = ~filtLevel;

   // ----------------------------------------
   // edge detection on the interrupt channels
   // ----------------------------------------
   // only the low sixteen channels are looked at
   assign srcBits = dataBits[NSRC-1:0];

   always @(posedge clk) begin
      if (!rstn) begin
         prevSrc_ff <= {NSRC{1'b0}};
      end else begin
         prevSrc_ff <= srcBits;
      end
   end

   assign riseEdge = srcBits & ~prevSrc_ff;
   assign fallEdge = ~srcBits & prevSrc_ff;

   // polarity per bit: one selects a rising data bit, zero a falling one
   assign edgeHit = (edgeRise_ff & riseEdge) | (~edgeRise_ff & fallEdge);
   // a disabled channel never sets its flag, so enabling later shows no stale event
   assign srcEvent = irqEn_ff & edgeHit;

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   // one select per control word; all but the group select are shared by the write and read paths
   assign selFilt = hit(regAddr, `IIP_OFF_FILT);
   assign selIrqEn = hit(regAddr, `IIP_OFF_IRQEN);
   assign selEdge = hit(regAddr, `IIP_OFF_EDGE);
   assign selStat = hit(regAddr, `IIP_OFF_STAT);
   assign selOvr = hit(regAddr, `IIP_OFF_OVR);
   assign selGrp = hit(regAddr, `IIP_OFF_GRP);

   // ----------------------------------------
   // status clear sources
   // ----------------------------------------
   assign wrStat = regWr && selStat;
   assign rdStat = regRd && selStat;
   assign wrOvr = regWr && selOvr;

   // a read clears exactly what it returned, so nothing unseen is lost
   assign statClr = (rdStat ? status_ff : {NSRC{1'b0}}) |
                    (wrStat ? regWdata[NSRC-1:0] : {NSRC{1'b0}});
   assign ovrClr = wrOvr ? regWdata[NSRC-1:0] : {NSRC{1'b0}};

   // ----------------------------------------
   // sticky status and overrun
   // ----------------------------------------
   // set wins over clear in the same cycle, so an event beside a read is kept
   always @* begin
      nxt_status = (status_ff & ~statClr) | srcEvent;
   end

   // status flags
   always @(posedge clk) begin
      if (!rstn) begin
         status_ff <= `IIP_STAT_RST;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // a second event on a flag nobody has cleared yet is remembered here
   always @* begin
      nxt_overrun = (overrun_ff & ~ovrClr) | (srcEvent & status_ff & ~statClr);
   end

   // overrun flags, cleared only by writing ones
   always @(posedge clk) begin
      if (!rstn) begin
         overrun_ff <= `IIP_STAT_RST;
      end else begin
         overrun_ff <= nxt_overrun;
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   // filter interval; zero keeps every channel in bypass
   always @(posedge clk) begin
      if (!rstn) begin
         filtSet_ff <= `IIP_FILT_RST;
      end else if (regWr && selFilt) begin
         filtSet_ff <= regWdata[15:0];
      end
   end

   // per channel interrupt enables
   always @(posedge clk) begin
      if (!rstn) begin
         irqEn_ff <= `IIP_IRQEN_RST;
      end else if (regWr && selIrqEn) begin
         irqEn_ff <= regWdata[NSRC-1:0];
      end
   end

   // per channel edge polarity
   always @(posedge clk) begin
      if (!rstn) begin
         edgeRise_ff <= `IIP_EDGE_RST;
      end else if (regWr && selEdge) begin
         edgeRise_ff <= regWdata[NSRC-1:0];
      end
   end

   // ----------------------------------------
   // interrupt merge
   // ----------------------------------------
   // clearing an enable also hides a flag that is already pending
   assign pendMasked = status_ff & irqEn_ff;

   // groups of four, then one request
   always @* begin
      for (g = 0; g < `IIP_GROUPS; g = g + 1) begin
         grpReq[g] = groupAny(pendMasked, g);
      end
   end

   // one level request for the whole port
   always @* begin
      nxt_irq = |grpReq;
   end

   always @(posedge clk) begin
      if (!rstn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   // active high; the bus pad drives the low-active request line
   assign irqReq = irq_ff;

   // ----------------------------------------
   // register read path
   // ----------------------------------------
   // data one cycle after the strobe, zero otherwise and for unmapped words
   always @* begin
      nxt_rdata = 32'h00000000;
      if (regRd) begin
         if (hit(regAddr, `IIP_OFF_DATA0)) begin
            nxt_rdata = dataBits[31:0];
         end else if (hit(regAddr, `IIP_OFF_DATA1)) begin
            nxt_rdata = dataBits[63:32];
         end else if (hit(regAddr, `IIP_OFF_DATA2)) begin
            nxt_rdata = dataBits[95:64];
         end else if (hit(regAddr, `IIP_OFF_DATA3)) begin
            nxt_rdata = dataBits[127:96];
         end else if (selFilt) begin
            nxt_rdata = {16'h0000, filtSet_ff};
         end else if (selIrqEn) begin
            nxt_rdata = {16'h0000, irqEn_ff};
         end else if (selEdge) begin
            nxt_rdata = {16'h0000, edgeRise_ff};
         end else if (selStat) begin
            nxt_rdata = {16'h0000, status_ff};
         end else if (selOvr) begin
            nxt_rdata = {16'h0000, overrun_ff};
         end else if (selGrp) begin
            nxt_rdata = {28'h0000000, grpReq};
         end
      end
   end

   // 32-bit word per access; never stalls the master
   always @(posedge clk) begin
      if (!rstn) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign regRdata = rdata_ff;

endmodule // iip_top

// File: tb/iip_pin_model.sv
// external switches on the input pins; high is the idle level.
// assumes its tasks are called from the bench between clock edges.
`timescale 1ns/1ns
module iip_pin_model (
   input wire clk,
   output reg [127:0] pins
);
   initial pins = {128{1'b1}};
   // pin levels change only just after an edge
   task setPin(input [6:0] ch, input lvl);
      begin
         @(posedge clk);
         pins[ch] <= lvl;
      end
   endtask
   task setAll(input [127:0] v);
      begin
         @(posedge clk);
         pins <= v;
      end
   endtask
   // short low pulse, as from a bouncing contact
   task glitch(input [6:0] ch);
      begin
         setPin(ch, 1'b0);
         repeat (2) @(posedge clk);
         pins[ch] <= 1'b1;
      end
   endtask
endmodule // iip_pin_model

// File: tb/iip_top_properties.sv
// checker for the input port, watching its top ports only.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module iip_top_properties #(
   parameter NCH = 128,
   parameter NSRC = 16
) (
   input wire clk,
   input wire rstn,
   input wire [NCH-1:0] inPins,
   input wire [5:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   input wire [31:0] regRdata,
   input wire irqReq
);
   reg lastRd_ff;
   reg [5:0] lastAddr_ff;
   reg [15:0] enSh_ff;
   reg [15:0] filtSh_ff;
   reg [6:0] stable_ff;
   reg [NCH-1:0] prevPins_ff;
   wire [31:0] pinWord = ~inPins[lastAddr_ff[3:2]*32 +: 32];
   // shadows of the control words; pins must sit still before data compares
   always @(posedge clk) begin
      if (!rstn) begin
         lastRd_ff <= 1'b0;
         lastAddr_ff <= 6'h00;
         enSh_ff <= 16'h0000;
         filtSh_ff <= 16'h0000;
         stable_ff <= 7'h00;
         prevPins_ff <= inPins;
      end else begin
         lastRd_ff <= regRd;
         lastAddr_ff <= regAddr;
         prevPins_ff <= inPins;
         if (regWr && regAddr[5:2] == 4'h5)
            enSh_ff <= regWdata[15:0];
         if (regWr && regAddr[5:2] == 4'h4)
            filtSh_ff <= regWdata[15:0];
         // a filter change restarts the wait, its pipeline may lag
         if (inPins != prevPins_ff || (regWr && regAddr[5:2] == 4'h4))
            stable_ff <= 7'h00;
         else if (stable_ff != 7'h7F)
            stable_ff <= stable_ff + 7'h01;
      end
   end
   property p_rdata_idle;
      @(posedge clk) disable iff (!rstn) !lastRd_ff |-> regRdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
   property p_rst_quiet;
      @(posedge clk) !rstn |=> regRdata == 32'h0 && !irqReq;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
   property p_upper_zero;
      @(posedge clk) disable iff (!rstn)
         lastRd_ff && lastAddr_ff[5:2] inside {[4'h4:4'h9]} |-> regRdata[31:16] == 16'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("control word upper half set");
   property p_group_bits;
      @(posedge clk) disable iff (!rstn) lastRd_ff && lastAddr_ff[5:2] == 4'h9 |-> regRdata[31:4] == 28'h0;
   endproperty
   a_group_bits: assert property (p_group_bits) else $error("group word beyond four bits");
   property p_unmapped;
      @(posedge clk) disable iff (!rstn) lastRd_ff && lastAddr_ff[5:2] > 4'h9 |-> regRdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped word not zero");
   property p_irq_masked;
      @(posedge clk) disable iff (!rstn) enSh_ff == 16'h0 && $past(enSh_ff) == 16'h0 |-> !irqReq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("request with all sources off");
   property p_data_inv;
      @(posedge clk) disable iff (!rstn)
         lastRd_ff && lastAddr_ff[5:4] == 2'h0 && stable_ff > 7'h3F && filtSh_ff < 16'h5 |-> regRdata == pinWord;
   endproperty
   a_data_inv: assert property (p_data_inv) else $error("data word not inverted pins");
   property p_irq_rise;
      @(posedge clk) disable iff (!rstn) $rose(irqReq) |-> $past(enSh_ff) != 16'h0;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("request rose while disabled");
endmodule // iip_top_properties

bind iip_top iip_top_properties #(.NCH(NCH), .NSRC(NSRC)) i_iip_top_properties (.clk(clk), .rstn(rstn),
   .inPins(inPins), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .irqReq(irqReq));

// File: tb/testbench.sv
// self-checking bench for the input port: register tasks and scenarios.
// assumes the pin model drives every channel and the bench is bus master.
`timescale 1ns/1ns
`include "iip_defines.vh"
module testbench;
   reg clk;
   reg rstn;
   reg [5:0] regAddr;
   reg [31:0] regWdata;
   reg regWr;
   reg regRd;
   wire [31:0] regRdata;
   wire irqReq;
   wire [127:0] inPins;
   integer fail_count;
   integer n_checks;
   reg [5:0] a;
   reg [127:0] pat;
   iip_pin_model i_iip_pin_model (.clk(clk), .pins(inPins));
   iip_top i_iip_top (.clk(clk), .rstn(rstn), .inPins(inPins), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqReq(irqReq));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [5:0] ad, input [31:0] d);
      begin
         @(posedge clk);
         regAddr <= ad;
         regWdata <= d;
         regWr <= 1'b1;
         @(posedge clk);
         regWr <= 1'b0;
      end
   endtask
   // data are looked at only in the cycle after the strobe
   task rd(input [5:0] ad, input [31:0] e);
      begin
         @(posedge clk);
         regAddr <= ad;
         regRd <= 1'b1;
         @(posedge clk);
         regRd <= 1'b0;
         #1 chk(regRdata, e);
      end
   endtask
   // move channel 13, then check request, group and status (read clears)
   task step(input lvl, input [31:0] expStat);
      begin
         i_iip_pin_model.setPin(7'd13, lvl);
         repeat (12) @(posedge clk);
         #1 chk({31'h0, irqReq}, {31'h0, expStat[13]});
         rd(`IIP_OFF_GRP, {28'h0, expStat[13], 3'h0});
         rd(`IIP_OFF_STAT, expStat);
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", n_checks, fail_count);
         if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // watchdog: the run needs well under a thousand cycles
   initial begin
      #20000;
      fail_count = fail_count + 1;
      stop_test;
   end
   initial begin
      rstn = 1'b0;
      regAddr = 6'h00;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      fail_count = 0;
      n_checks = 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      for (a = 6'h10; a < 6'h28; a = a + 6'h04)
         rd(a, 32'h0);
      rd(6'h28, 32'h0);
      rd(6'h3C, 32'h0);
      // pattern on all pins, long enough for the checker's data compare too
      pat = {32'h0F0F1234, 32'hA5A50000, 32'hFFFF0001, 32'h7E81C3FF};
      i_iip_pin_model.setAll(pat);
      repeat (70) @(posedge clk);
      for (a = 6'h00; a < 6'h10; a = a + 6'h04)
         rd(a, ~pat[a[3:2]*32 +: 32]);
      wr(6'h00, 32'h12345678);
      rd(6'h00, ~pat[31:0]);
      i_iip_pin_model.setAll({128{1'b1}});
      // let the restored levels pass the edge detector before enabling
      repeat (8) @(posedge clk);
      wr(`IIP_OFF_IRQEN, 32'hFFFF2000);
      rd(`IIP_OFF_IRQEN, 32'h2000);
      // falling data edge selected first, then rising
      step(1'b0, 32'h0);
      step(1'b1, 32'h2000);
      wr(`IIP_OFF_EDGE, 32'h2000);
      step(1'b0, 32'h2000);
      step(1'b1, 32'h0);
      // pending flag masked by enable, then cleared by writing one
      i_iip_pin_model.setPin(7'd13, 1'b0);
      repeat (12) @(posedge clk);
      #1 chk({31'h0, irqReq}, 32'h1);
      // a second rising data edge before the flag is cleared sets overrun
      i_iip_pin_model.setPin(7'd13, 1'b1);
      repeat (8) @(posedge clk);
      i_iip_pin_model.setPin(7'd13, 1'b0);
      repeat (12) @(posedge clk);
      rd(`IIP_OFF_OVR, 32'h2000);
      wr(`IIP_OFF_OVR, 32'h2000);
      rd(`IIP_OFF_OVR, 32'h0);
      wr(`IIP_OFF_IRQEN, 32'h0);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, irqReq}, 32'h0);
      wr(`IIP_OFF_STAT, 32'h2000);
      rd(`IIP_OFF_STAT, 32'h0);
      // disabled channel 5 and plain channel 16 raise nothing
      wr(`IIP_OFF_IRQEN, 32'hFFDF);
      wr(`IIP_OFF_EDGE, 32'h0);
      i_iip_pin_model.setPin(7'd5, 1'b0);
      i_iip_pin_model.setPin(7'd16, 1'b0);
      repeat (12) @(posedge clk);
      i_iip_pin_model.setPin(7'd5, 1'b1);
      i_iip_pin_model.setPin(7'd16, 1'b1);
      repeat (12) @(posedge clk);
      #1 chk({31'h0, irqReq}, 32'h0);
      rd(`IIP_OFF_STAT, 32'h0);
      // short pulses must not pass a slow filter, a held level must
      wr(`IIP_OFF_FILT, 32'h4);
      rd(`IIP_OFF_FILT, 32'h4);
      repeat (3) begin
         i_iip_pin_model.glitch(7'd40);
         i_iip_pin_model.glitch(7'd12);
         repeat (10) @(posedge clk);
      end
      rd(6'h04, 32'h0);
      rd(`IIP_OFF_STAT, 32'h0);
      i_iip_pin_model.setPin(7'd40, 1'b0);
      repeat (40) @(posedge clk);
      rd(6'h04, 32'h100);
      stop_test;
   end
endmodule // testbench
